/* File: logic/tamper_pkg.sv */
// Purpose: shared constants for the battery-mode tamper detector
// Assumes: 50 MHz system clock, 8-bit register data, 16-bit register addresses
// Notes: phase samples are signed codes of the positive current terminals
package tamper_pkg;

  // register addresses
  localparam logic [15:0] THRESH_PERIOD_ADDR = 16'hec00;
  localparam logic [15:0] SECOND_CONFIG_ADDR = 16'hec01;

  // register reset values
  localparam logic [7:0] THRESH_PERIOD_RESET = 8'h00;
  localparam logic [7:0] SECOND_CONFIG_RESET = 8'h00;

  // field positions
  localparam int PERIOD_LSB = 3;
  localparam int PERIOD_WIDTH = 5;
  localparam int THRESH_LSB = 0;
  localparam int THRESH_WIDTH = 3;
  localparam int NO_TAMPER_DIS_BIT = 2;

  // threshold field codes, levels referenced to current gain of one
  localparam logic [2:0] THRESH_CODE_71MV = 3'h0;
  localparam logic [2:0] THRESH_CODE_1MV = 3'h3;
  localparam logic [2:0] THRESH_CODE_0P471MV = 3'h7;

  // power mode codes as {mode_pin_1, mode_pin_0}
  localparam logic [1:0] FULL_OPERATION_MODE = 2'h1;
  localparam logic [1:0] MEAN_ABS_MODE = 2'h0;
  localparam logic [1:0] LOW_POWER_MONITOR_MODE = 2'h2;
  localparam logic [1:0] SLEEP_STATE = 2'h3;

  // timing: one base tick is 20 ms
  localparam int TICK_MS = 20;
  localparam int CLK_KHZ = 50_000;
  localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
  localparam logic [5:0] PERIOD_BASE_TICKS = 6'h0a;
  localparam logic [5:0] TAMPER_MARGIN = 6'h01;

  // pin synchroniser depth
  localparam int SYNC_STAGES = 3;

endpackage : tamper_pkg

/* File: logic/pin_sync.sv */
// Purpose: three-stage synchroniser for slow pin levels
// Assumes: pins change far slower than the clock
// Notes: output follows only when stages two and three agree
module pin_sync
  import tamper_pkg::*;
#(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_LEVEL = '1
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } sync_s;

  sync_s s;
  sync_s next_s;

  // shift chain, accept a value once it is stable over two stages
  always_comb
  begin
    next_s = s;
    next_s.s1 = pin_in;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3)
    begin
      next_s.level = s.s3;
    end
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      s <= '{s1: RESET_LEVEL, s2: RESET_LEVEL, s3: RESET_LEVEL, level: RESET_LEVEL};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign level_out = s.level;

endmodule : pin_sync

/* File: logic/phase_crossing_counter.sv */
// Purpose: counts upward threshold crossings of one phase current
// Assumes: samples arrive on sample_valid from same-clock front end logic
// Notes: count saturates at its top value
module phase_crossing_counter
  import tamper_pkg::*;
#(
  parameter int SAMPLE_WIDTH = 16,
  parameter int COUNT_WIDTH = 6
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic enable,
  input wire logic sample_valid,
  input wire logic [SAMPLE_WIDTH-1:0] sample,
  input wire logic [SAMPLE_WIDTH-1:0] threshold,
  output logic [COUNT_WIDTH-1:0] count
);

  typedef struct packed {
    logic above;
    logic [COUNT_WIDTH-1:0] count;
  } counter_s;

  counter_s s;
  counter_s next_s;
  logic above_now;

  // peak compare on the positive terminal only, count each rise above
  always_comb
  begin
    next_s = s;
    above_now = $signed(sample) > $signed(threshold);
    if (clear)
    begin
      next_s = '0;
    end
    else if (enable && sample_valid)
    begin
      next_s.above = above_now;
      if (above_now && !s.above && (s.count != '1))
      begin
        next_s.count = s.count + 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign count = s.count;

endmodule : phase_crossing_counter

/* File: logic/low_power_tamper_detector.sv */
// Purpose: battery-mode current monitor that flags missing neutral tamper
// Assumes: mode pins come from the host asynchronously; samples are same-clock
// Notes: register port answers only in full operation mode
module low_power_tamper_detector
  import tamper_pkg::*;
#(
  parameter int SAMPLE_WIDTH = 16,
  parameter int COUNT_WIDTH = 6,
  parameter int TICK_CLOCKS = TICK_CYCLES,
  parameter logic [SAMPLE_WIDTH-1:0] LEVEL_71MV = 16'h1000,
  parameter logic [SAMPLE_WIDTH-1:0] LEVEL_1MV = 16'h003a,
  parameter logic [SAMPLE_WIDTH-1:0] LEVEL_0P471MV = 16'h001b
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic mode_pin_1,
  input wire logic mode_pin_0,
  input wire logic sample_valid,
  input wire logic [SAMPLE_WIDTH-1:0] phase_a_positive_input,
  input wire logic [SAMPLE_WIDTH-1:0] phase_b_positive_input,
  input wire logic [SAMPLE_WIDTH-1:0] phase_c_positive_input,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic tamper_irq_n,
  output logic no_tamper_irq_n,
  output logic low_power_monitor_mode
);

  localparam int PHASES = 3;
  // tick counter wide enough for one whole base tick
  localparam int TW = $clog2(TICK_CLOCKS + 1);
  // last count of a tick, so a tick lasts exactly TICK_CLOCKS cycles
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CLOCKS - 1);

  // sequencer: idle outside monitoring, done once an outcome is out
  typedef enum logic [1:0] {
    idle_st,
    measure_st,
    done_st
  } meas_e;

  // whole block state, registered as one word
  typedef struct packed {
    meas_e st;
    logic [7:0] thresh_period;
    logic [7:0] second_cfg;
    logic [1:0] mode_prev;
    logic [TW-1:0] tick_cnt;
    logic [5:0] tick_num;
    logic counters_clear;
    logic tamper_irq_n;
    logic no_tamper_irq_n;
    logic [7:0] reg_rdata;
    logic monitor_active;
  } state_s;

  // reset releases both outcome pins and takes the mode as sleep
  localparam state_s RESET_STATE = '{
    st: idle_st,
    thresh_period: THRESH_PERIOD_RESET,
    second_cfg: SECOND_CONFIG_RESET,
    mode_prev: SLEEP_STATE,
    tick_cnt: '0,
    tick_num: 6'h00,
    counters_clear: 1'b1,
    tamper_irq_n: 1'b1,
    no_tamper_irq_n: 1'b1,
    reg_rdata: 8'h00,
    monitor_active: 1'b0
  };

  state_s s;
  state_s next_s;
  logic [1:0] mode;
  logic [SAMPLE_WIDTH-1:0] samples [PHASES];
  logic [COUNT_WIDTH-1:0] counts [PHASES];
  logic [PHASES-1:0] over_limit;
  logic [SAMPLE_WIDTH-1:0] threshold;
  logic [5:0] period_value;
  logic [5:0] tamper_limit;
  logic [5:0] period_end;
  logic single_pin;
  logic any_tamper;
  logic counting;

  // mode pins cross in through three flops; pull-ups make sleep the rest level
  pin_sync #(
    .WIDTH(2),
    .RESET_LEVEL(SLEEP_STATE)
  ) mode_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin_in({mode_pin_1, mode_pin_0}),
    .level_out(mode)
  );

  assign samples[0] = phase_a_positive_input;
  assign samples[1] = phase_b_positive_input;
  assign samples[2] = phase_c_positive_input;

  // one crossing counter per phase
  generate
    for (genvar p = 0; p < PHASES; p++)
    begin : g_phase
      phase_crossing_counter #(
        .SAMPLE_WIDTH(SAMPLE_WIDTH),
        .COUNT_WIDTH(COUNT_WIDTH)
      ) counter (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .clear(s.counters_clear),
        .enable(counting),
        .sample_valid(sample_valid),
        .sample(samples[p]),
        .threshold(threshold),
        .count(counts[p])
      );
      assign over_limit[p] = 6'(counts[p]) >= tamper_limit;
    end
  endgenerate

  // threshold level from the field; reserved codes fall back to the top level
  always_comb
  begin
    unique case (s.thresh_period[THRESH_LSB +: THRESH_WIDTH])
      THRESH_CODE_1MV: threshold = LEVEL_1MV;
      THRESH_CODE_0P471MV: threshold = LEVEL_0P471MV;
      default: threshold = LEVEL_71MV;
    endcase
  end

  // derived limits from the period field
  always_comb
  begin
    period_value = {1'b0, s.thresh_period[PERIOD_LSB +: PERIOD_WIDTH]};
    tamper_limit = period_value + TAMPER_MARGIN;
    period_end = period_value + PERIOD_BASE_TICKS;
    single_pin = s.second_cfg[NO_TAMPER_DIS_BIT];
    any_tamper = |over_limit;
    counting = (s.st == measure_st) && (mode == LOW_POWER_MONITOR_MODE);
  end

  // next-state: registers, mode tracking and measurement sequencing
  always_comb
  begin
    next_s = s;
    next_s.counters_clear = 1'b0;
    next_s.mode_prev = mode;
    next_s.monitor_active = (mode == LOW_POWER_MONITOR_MODE);

    // register port only in full operation; silent while monitoring
    if (mode == FULL_OPERATION_MODE)
    begin
      if (reg_wr)
      begin
        if (reg_addr == THRESH_PERIOD_ADDR)
        begin
          next_s.thresh_period = reg_wdata;
        end
        else if (reg_addr == SECOND_CONFIG_ADDR)
        begin
          next_s.second_cfg = reg_wdata;
        end
      end
      if (reg_rd)
      begin
        if (reg_addr == THRESH_PERIOD_ADDR)
        begin
          next_s.reg_rdata = s.thresh_period;
        end
        else if (reg_addr == SECOND_CONFIG_ADDR)
        begin
          next_s.reg_rdata = s.second_cfg;
        end
        else
        begin
          next_s.reg_rdata = 8'h00;
        end
      end
    end

    // sleep drops the single-pin choice
    if (mode == SLEEP_STATE)
    begin
      next_s.second_cfg[NO_TAMPER_DIS_BIT] = 1'b0;
    end

    // any mode change releases the outcome pins and ends a measurement
    // a change landing on a period end drops that outcome: the new mode wins
    if (mode != s.mode_prev)
    begin
      next_s.tamper_irq_n = 1'b1;
      next_s.no_tamper_irq_n = 1'b1;
      next_s.st = idle_st;
      if (mode == LOW_POWER_MONITOR_MODE)
      begin
        next_s.counters_clear = 1'b1;
        next_s.tick_cnt = '0;
        next_s.tick_num = 6'h00;
        next_s.st = measure_st;
      end
    end
    else
    begin
      unique case (s.st)
        idle_st:
        begin
          next_s.st = idle_st;
        end
        measure_st:
        begin
          // base tick timer
          if (s.tick_cnt == TICK_LAST)
          begin
            next_s.tick_cnt = '0;
            if (s.tick_num != 6'h3f)
            begin
              next_s.tick_num = s.tick_num + 6'h01;
            end
          end
          else
          begin
            next_s.tick_cnt = s.tick_cnt + 1'b1;
          end
          if (single_pin)
          begin
            // counts run on with no period end until a tamper is flagged; flag tamper only
            if (any_tamper)
            begin
              next_s.tamper_irq_n = 1'b0;
              next_s.st = done_st;
            end
          end
          else if ((s.tick_cnt == TICK_LAST) && ((s.tick_num + 6'h01) == period_end))
          begin
            // end of the measurement period
            if (any_tamper)
            begin
              next_s.tamper_irq_n = 1'b0;
            end
            else
            begin
              next_s.no_tamper_irq_n = 1'b0;
            end
            next_s.st = done_st;
          end
        end
        done_st:
        begin
          next_s.st = done_st;
        end
        // the fourth code is never used; recover to idle if it shows
        default:
        begin
          next_s.st = idle_st;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      s <= RESET_STATE;
    end
    else
    begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign reg_rdata = s.reg_rdata;
  assign tamper_irq_n = s.tamper_irq_n;
  assign no_tamper_irq_n = s.no_tamper_irq_n;
  assign low_power_monitor_mode = s.monitor_active;

endmodule : low_power_tamper_detector

/* File: bench/host_model.sv */
// Purpose: host that sets the power mode pins
// Assumes: pins change at the falling clock edge
// Notes: pins rest at sleep, as the pull-ups leave them
module host_model
(
  input wire logic sys_clk,
  output logic mode_pin_1,
  output logic mode_pin_0
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] SLEEP_CODE = 2'h3;
  // pins start in sleep
  initial {mode_pin_1, mode_pin_0} = SLEEP_CODE;
  // new mode, set off the sampling edge
  task automatic set_mode(input logic [1:0] m);
    @(negedge sys_clk);
    {mode_pin_1, mode_pin_0} = m;
  endtask : set_mode
endmodule : host_model

/* File: bench/tamper_properties.sv */
// Purpose: port checks for the tamper detector
// Assumes: TICK_CLOCKS matches the instance
// Notes: mode pins are the cause, outputs the effect
module tamper_properties
  import tamper_pkg::*;
#(
  parameter int TICK_CLOCKS = TICK_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic mode_pin_1,
  input wire logic mode_pin_0,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic tamper_irq_n,
  input wire logic no_tamper_irq_n,
  input wire logic low_power_monitor_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned mon_cnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // cycles spent in monitoring
  always_ff @(posedge sys_clk)
  begin
    mon_cnt <= low_power_monitor_mode ? mon_cnt + 1 : 0;
  end
  a_reset_idle: assert property (disable iff (1'b0) !rstn |=> tamper_irq_n && no_tamper_irq_n && !reg_rdata)
    else $error("outputs not idle after reset");
  a_one_outcome: assert property (tamper_irq_n || no_tamper_irq_n)
    else $error("both outcome pins low");
  a_release_mode: assert property ($rose(tamper_irq_n) |-> ##[0:1] !low_power_monitor_mode)
    else $error("tamper pin released inside monitoring");
  a_clear_held: assert property (!no_tamper_irq_n |=> (!no_tamper_irq_n or ##[0:1] !low_power_monitor_mode))
    else $error("no tamper pin released inside monitoring");
  a_port_silent: assert property (low_power_monitor_mode && reg_rd |=> $stable(reg_rdata))
    else $error("read answered in monitoring");
  a_period_min: assert property ($fell(no_tamper_irq_n) |-> mon_cnt >= 10 * TICK_CLOCKS - 2)
    else $error("outcome before the period ended");
  a_mode_on: assert property (({mode_pin_1, mode_pin_0} == 2'h2) [*6] |-> low_power_monitor_mode)
    else $error("monitor mode not seen");
  a_mode_off: assert property (({mode_pin_1, mode_pin_0} != 2'h2) [*6] |-> !low_power_monitor_mode)
    else $error("monitor flag without monitor pins");
endmodule : tamper_properties

/* File: bench/tb.sv */
// Purpose: self-checking bench for the tamper detector
// Assumes: tick shortened to ten clocks; levels at unity gain
// Notes: table rows cover two-pin outcomes, hand tests the rest
module tb
  import tamper_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 10;
  typedef struct {logic [4:0] p; logic [2:0] code; logic [15:0] lvl; int n; int ph; logic tmp;} row_s;
  // period, code, level, crossings, phase, tamper expected
  row_s rows [5] = '{'{2, 3'h0, 16'h1100, 3, 0, 1}, '{2, 3'h0, 16'h1100, 2, 1, 0},
    '{0, 3'h3, 16'h0040, 1, 2, 1}, '{1, 3'h7, 16'h0010, 5, 0, 0}, '{3, 3'h7, 16'h0020, 4, 1, 1}};
  logic sys_clk = 0, rstn = 0, sample_valid = 0, reg_wr = 0, reg_rd = 0;
  logic mode_pin_1, mode_pin_0, tamper_irq_n, no_tamper_irq_n, low_power_monitor_mode;
  logic [15:0] ph [3] = '{16'h0000, 16'h0000, 16'h0000};
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  int error_cnt = 0, n_tests = 0, t, since_mon = 0, e;
  always #10 sys_clk = ~sys_clk;
  // cycles since monitoring began
  always @(posedge sys_clk) since_mon <= low_power_monitor_mode ? since_mon + 1 : 0;
  host_model u_host (.sys_clk(sys_clk), .mode_pin_1(mode_pin_1), .mode_pin_0(mode_pin_0));
  low_power_tamper_detector #(.TICK_CLOCKS(TK)) u_dut (.sys_clk(sys_clk), .rstn(rstn),
    .mode_pin_1(mode_pin_1), .mode_pin_0(mode_pin_0), .sample_valid(sample_valid),
    .phase_a_positive_input(ph[0]), .phase_b_positive_input(ph[1]), .phase_c_positive_input(ph[2]),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tamper_irq_n(tamper_irq_n), .no_tamper_irq_n(no_tamper_irq_n),
    .low_power_monitor_mode(low_power_monitor_mode));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // one strobed register access
  task automatic reg_op(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    @(negedge sys_clk);
    reg_wr = 0;
    reg_rd = 0;
    @(negedge sys_clk);
  endtask : reg_op
  // mode change, then the synchroniser settles
  task automatic enter(input logic [1:0] m);
    u_host.set_mode(m);
    repeat (6) @(negedge sys_clk);
    check("monitor flag", low_power_monitor_mode, m == LOW_POWER_MONITOR_MODE);
  endtask : enter
  // n upward crossings on one phase
  task automatic pulses(input int p, input logic [15:0] lvl, input int n);
    repeat (n)
    begin
      @(negedge sys_clk);
      sample_valid = 1;
      ph[p] = lvl;
      @(negedge sys_clk);
      ph[p] = 16'h0000;
    end
    @(negedge sys_clk);
    sample_valid = 0;
  endtask : pulses
  // bounded wait for an outcome pin
  task automatic wait_out(input int lim);
    t = 0;
    while (tamper_irq_n === 1'b1 && no_tamper_irq_n === 1'b1 && t < lim)
    begin
      @(negedge sys_clk);
      t++;
    end
    if (t >= lim)
    begin
      check("outcome timeout", 1, 0);
      summarize();
    end
  endtask : wait_out
  // main sequence
  initial
  begin
    repeat (12) @(negedge sys_clk);
    rstn = 1;
    foreach (rows[i])
    begin
      enter(FULL_OPERATION_MODE);
      check("pins idle", {tamper_irq_n, no_tamper_irq_n}, 2'h3);
      reg_op(1, THRESH_PERIOD_ADDR, {rows[i].p, rows[i].code});
      reg_op(0, THRESH_PERIOD_ADDR, 8'h00);
      check("period and threshold", reg_rdata, {rows[i].p, rows[i].code});
      enter(LOW_POWER_MONITOR_MODE);
      pulses(rows[i].ph, rows[i].lvl, rows[i].n);
      e = TK * (rows[i].p + 10);
      wait_out(e + 20);
      check("period length", since_mon >= e - 2 && since_mon <= e + 4, 1);
      check("tamper pin", tamper_irq_n, !rows[i].tmp);
      check("no tamper pin", no_tamper_irq_n, rows[i].tmp);
    end
    reg_op(1, THRESH_PERIOD_ADDR, 8'hff);
    reg_op(0, SECOND_CONFIG_ADDR, 8'h00);
    check("read in monitoring", reg_rdata, 8'h1f);
    enter(FULL_OPERATION_MODE);
    reg_op(0, THRESH_PERIOD_ADDR, 8'h00);
    check("write in monitoring", reg_rdata, 8'h1f);
    reg_op(0, 16'hec02, 8'h00);
    check("unmapped read", reg_rdata, 8'h00);
    reg_op(1, THRESH_PERIOD_ADDR, 8'h20);
    reg_op(1, SECOND_CONFIG_ADDR, 8'h04);
    reg_op(0, SECOND_CONFIG_ADDR, 8'h00);
    check("second config", reg_rdata, 8'h04);
    enter(LOW_POWER_MONITOR_MODE);
    repeat (TK * 14 + 20) @(negedge sys_clk);
    check("single pin quiet", {tamper_irq_n, no_tamper_irq_n}, 2'h3);
    pulses(2, 16'h1100, 5);
    wait_out(20);
    check("late tamper", {tamper_irq_n, no_tamper_irq_n}, 2'h1);
    enter(MEAN_ABS_MODE);
    check("pins after tamper", {tamper_irq_n, no_tamper_irq_n}, 2'h3);
    reg_op(1, THRESH_PERIOD_ADDR, 8'hff);
    enter(SLEEP_STATE);
    enter(LOW_POWER_MONITOR_MODE);
    wait_out(TK * 14 + 20);
    check("two pin again", {tamper_irq_n, no_tamper_irq_n}, 2'h2);
    enter(FULL_OPERATION_MODE);
    reg_op(0, THRESH_PERIOD_ADDR, 8'h00);
    check("write in mean mode", reg_rdata, 8'h20);
    reg_op(0, SECOND_CONFIG_ADDR, 8'h00);
    check("sleep clears single pin", reg_rdata, 8'h00);
    reg_op(1, SECOND_CONFIG_ADDR, 8'h0b);
    rstn = 0;
    repeat (12) @(negedge sys_clk);
    rstn = 1;
    repeat (6) @(negedge sys_clk);
    reg_op(0, THRESH_PERIOD_ADDR, 8'h00);
    check("reset period reg", reg_rdata, THRESH_PERIOD_RESET);
    reg_op(0, SECOND_CONFIG_ADDR, 8'h00);
    check("reset config reg", reg_rdata, SECOND_CONFIG_RESET);
    summarize();
  end
endmodule : tb
bind low_power_tamper_detector tamper_properties #(.TICK_CLOCKS(TICK_CLOCKS)) u_props (.sys_clk(sys_clk),
  .rstn(rstn), .mode_pin_1(mode_pin_1), .mode_pin_0(mode_pin_0), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .tamper_irq_n(tamper_irq_n), .no_tamper_irq_n(no_tamper_irq_n),
  .low_power_monitor_mode(low_power_monitor_mode));
